// ==== tmc_mode_ctrl.sv ====
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
module tmc_mode_ctrl
	import tmc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [3:0]  avsAddress,
	input  wire logic        avsRead,
	input  wire logic        avsWrite,
	input  wire logic [31:0] avsWriteData,
	input  wire logic [3:0]  avsByteEnable,
	output logic      [31:0] avsReadData,
	output logic             avsWaitRequest,
	input  wire logic        cpuHalted,
	output logic             wideMode,
	output logic             wideClockMode,
	output logic [1:0]       firstOp,
	output logic             firstPwm,
	output logic             firstEdgeTime,
	output logic [1:0]       secondOp,
	output logic             secondPwm,
	output logic             secondEdgeTime,
	output logic             firstRun,
	output logic             secondRun,
	output logic             firstRiseArm,
	output logic             firstFallArm,
	output logic             secondRiseArm,
	output logic             secondFallArm,
	output logic             firstTrigEn,
	output logic             secondTrigEn,
	output logic             firstInvert,
	output logic             secondInvert,
	output logic             clockCountEn
);

	typedef struct packed {
		logic [2:0]  cfg;
		logic [3:0]  firstMode;
		logic [3:0]  secondMode;
		logic [14:0] ctl;
		logic [1:0]  halt;
		logic        ack;
		logic        waitReq;
		logic [31:0] rdata;
		logic        wide;
		logic        wideClock;
		logic [1:0]  op1;
		logic        pwm1;
		logic        et1;
		logic [1:0]  op2;
		logic        pwm2;
		logic        et2;
		logic        run1;
		logic        run2;
		logic [3:0]  arm;
		logic [1:0]  trig;
		logic [1:0]  inv;
		logic        rtc;
	} tmc_state_s;

	tmc_state_s state_reg;
	tmc_state_s state_next;

	// Operating kind from a mode field; reserved code means no operation
	function automatic tmc_op_e tmc_decode_op(input logic [1:0] field);
		unique case (field)
			TMC_MODE_ONESHOT:  tmc_decode_op = TMC_OP_ONESHOT;
			TMC_MODE_PERIODIC: tmc_decode_op = TMC_OP_PERIODIC;
			TMC_MODE_CAPTURE:  tmc_decode_op = TMC_OP_CAPTURE;
			default:           tmc_decode_op = TMC_OP_OFF;
		endcase
	endfunction

	// Edge arms {fall, rise}; reserved code arms nothing
	function automatic logic [1:0] tmc_decode_edge(input logic [1:0] sel);
		unique case (sel)
			TMC_EDGE_RISE: tmc_decode_edge = 2'h1;
			TMC_EDGE_FALL: tmc_decode_edge = 2'h2;
			TMC_EDGE_BOTH: tmc_decode_edge = 2'h3;
			default:       tmc_decode_edge = 2'h0;
		endcase
	endfunction

	// Merge a write into a register under byte enables
	function automatic logic [31:0] tmc_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		tmc_merge = res;
	endfunction

	logic [1:0]  ctlEdge1;
	logic [1:0]  ctlEdge2;
	logic [3:0]  effSecondMode;
	logic        isWide;
	logic        busReq;
	logic        haltSync;

	// Bus, register update and decoded controls
	always_comb begin
		logic [31:0] merged;
		merged = 32'h0000_0000;
		state_next = state_reg;
		busReq = (avsRead || avsWrite) && !state_reg.ack;
		haltSync = state_reg.halt[1];
		state_next.halt = {state_reg.halt[0], cpuHalted};
		state_next.ack = busReq;
		state_next.waitReq = !busReq; // Own flop, so the pin needs no inverter
		// A write lands on the acknowledge edge, one cycle after the request arrives
		if (busReq && avsWrite) begin
			unique case (avsAddress)
				TMC_GLOBAL_CFG_OFS: begin
					merged = tmc_merge({29'h0, state_reg.cfg}, avsWriteData, avsByteEnable);
					state_next.cfg = merged[2:0];
				end
				TMC_FIRST_MODE_OFS: begin
					merged = tmc_merge({28'h0, state_reg.firstMode}, avsWriteData, avsByteEnable);
					state_next.firstMode = merged[3:0];
				end
				TMC_SECOND_MODE_OFS: begin
					merged = tmc_merge({28'h0, state_reg.secondMode}, avsWriteData,
						avsByteEnable);
					state_next.secondMode = merged[3:0];
				end
				TMC_CONTROL_OFS: begin
					merged = tmc_merge({17'h0, state_reg.ctl}, avsWriteData, avsByteEnable);
					state_next.ctl = merged[14:0] & TMC_CONTROL_WMASK;
				end
				default: begin
				end
			endcase
		end
		// Read data; unmapped offsets and reserved bits answer zero
		state_next.rdata = 32'h0000_0000;
		if (busReq && avsRead) begin
			unique case (avsAddress)
				TMC_GLOBAL_CFG_OFS:  state_next.rdata = {29'h0, state_reg.cfg};
				TMC_FIRST_MODE_OFS:  state_next.rdata = {28'h0, state_reg.firstMode};
				TMC_SECOND_MODE_OFS: state_next.rdata = {28'h0, state_reg.secondMode};
				TMC_CONTROL_OFS:     state_next.rdata = {17'h0, state_reg.ctl};
				default:             state_next.rdata = 32'h0000_0000;
			endcase
		end
		// Global configuration: codes 2 and 3 reserved, treated as split
		isWide = (state_reg.cfg == TMC_CFG_WIDE_TIMER) ||
			(state_reg.cfg == TMC_CFG_WIDE_CLOCK);
		state_next.wide = isWide;
		state_next.wideClock = (state_reg.cfg == TMC_CFG_WIDE_CLOCK);
		// In wide setup the second register is ignored in favour of the first
		effSecondMode = isWide ? state_reg.firstMode : state_reg.secondMode;
		state_next.op1 = tmc_decode_op(state_reg.firstMode[1:0]);
		state_next.pwm1 = state_reg.firstMode[TMC_ALT_MODE_BIT];
		state_next.et1 = state_reg.firstMode[TMC_CAPTURE_KIND_BIT];
		state_next.op2 = tmc_decode_op(effSecondMode[1:0]);
		state_next.pwm2 = effSecondMode[TMC_ALT_MODE_BIT];
		state_next.et2 = effSecondMode[TMC_CAPTURE_KIND_BIT];
		// Stall freezes only while the processor is halted
		state_next.run1 = state_reg.ctl[TMC_FIRST_EN_BIT] &&
			!(state_reg.ctl[TMC_FIRST_STALL_BIT] && haltSync);
		state_next.run2 = state_reg.ctl[TMC_SECOND_EN_BIT] &&
			!(state_reg.ctl[TMC_SECOND_STALL_BIT] && haltSync);
		ctlEdge1 = state_reg.ctl[TMC_FIRST_EDGE_LSB +: 2];
		ctlEdge2 = state_reg.ctl[TMC_SECOND_EDGE_LSB +: 2];
		state_next.arm = {tmc_decode_edge(ctlEdge2), tmc_decode_edge(ctlEdge1)};
		state_next.trig = {state_reg.ctl[TMC_SECOND_TRIG_BIT],
			state_reg.ctl[TMC_FIRST_TRIG_BIT]};
		state_next.inv = {state_reg.ctl[TMC_SECOND_INV_BIT],
			state_reg.ctl[TMC_FIRST_INV_BIT]};
		state_next.rtc = state_reg.ctl[TMC_CLOCK_COUNT_BIT];
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.cfg <= TMC_GLOBAL_CFG_RST;
			state_reg.firstMode <= TMC_MODE_RST;
			state_reg.secondMode <= TMC_MODE_RST;
			state_reg.ctl <= TMC_CONTROL_RST;
			state_reg.waitReq <= 1'b1; // Idle bus shows wait
		end else begin
			state_reg <= state_next;
		end
	end

	// Waitrequest is low only in the acknowledge cycle, so every access takes two
	assign avsWaitRequest = state_reg.waitReq;
	assign avsReadData    = state_reg.rdata;
	assign wideMode       = state_reg.wide;
	assign wideClockMode  = state_reg.wideClock;
	assign firstOp        = state_reg.op1;
	assign firstPwm       = state_reg.pwm1;
	assign firstEdgeTime  = state_reg.et1;
	assign secondOp       = state_reg.op2;
	assign secondPwm      = state_reg.pwm2;
	assign secondEdgeTime = state_reg.et2;
	assign firstRun       = state_reg.run1;
	assign secondRun      = state_reg.run2;
	assign firstRiseArm   = state_reg.arm[0];
	assign firstFallArm   = state_reg.arm[1];
	assign secondRiseArm  = state_reg.arm[2];
	assign secondFallArm  = state_reg.arm[3];
	assign firstTrigEn    = state_reg.trig[0];
	assign secondTrigEn   = state_reg.trig[1];
	assign firstInvert    = state_reg.inv[0];
	assign secondInvert   = state_reg.inv[1];
	assign clockCountEn   = state_reg.rtc;

	// Mode field decode follows the register
	property p_second_op;
		@(posedge ref_clk) disable iff (rst)
		(!state_reg.wide && state_reg.secondMode[1:0] == 2'h2 &&
			$stable(state_reg.secondMode) && $stable(state_reg.cfg))
		|=> secondOp == TMC_OP_PERIODIC;
	endproperty
	a_second_op: assert property (p_second_op) else $error("second op decode wrong");

	property p_second_pwm;
		@(posedge ref_clk) disable iff (rst)
		(!state_reg.wide && $stable(state_reg.cfg)) |=> secondPwm == $past(state_reg.secondMode[3]);
	endproperty
	a_second_pwm: assert property (p_second_pwm) else $error("second pwm select wrong");

	property p_second_et;
		@(posedge ref_clk) disable iff (rst)
		(!state_reg.wide && $stable(state_reg.cfg)) |=> secondEdgeTime == $past(state_reg.secondMode[2]);
	endproperty
	a_second_et: assert property (p_second_et) else $error("second capture kind wrong");

	property p_wide_uses_first;
		@(posedge ref_clk) disable iff (rst)
		(state_reg.cfg == TMC_CFG_WIDE_TIMER) |=> secondPwm == $past(state_reg.firstMode[3]);
	endproperty
	a_wide_uses_first: assert property (p_wide_uses_first) else $error("wide mode source");

	property p_reserved_read;
		@(posedge ref_clk) disable iff (rst)
		!avsWaitRequest |-> (avsReadData[12] == 1'b0 && avsReadData[7] == 1'b0 &&
			avsReadData[31:15] == 17'h0);
	endproperty
	a_reserved_read: assert property (p_reserved_read) else $error("reserved bit read high");

	property p_ctl_write;
		@(posedge ref_clk) disable iff (rst)
		(avsWrite && avsWaitRequest && avsAddress == TMC_CONTROL_OFS && avsByteEnable == 4'hF)
		|=> state_reg.ctl == ($past(avsWriteData[14:0]) & TMC_CONTROL_WMASK);
	endproperty
	a_ctl_write: assert property (p_ctl_write) else $error("control write lost");

	property p_stall;
		@(posedge ref_clk) disable iff (rst)
		(state_reg.ctl[TMC_FIRST_STALL_BIT] && state_reg.halt[1]) |=> !firstRun;
	endproperty
	a_stall: assert property (p_stall) else $error("first timer runs while stalled");

	property p_enable;
		@(posedge ref_clk) disable iff (rst)
		(state_reg.ctl[TMC_SECOND_EN_BIT] && !state_reg.ctl[TMC_SECOND_STALL_BIT])
		|=> secondRun;
	endproperty
	a_enable: assert property (p_enable) else $error("second timer not running");

	property p_edge_both;
		@(posedge ref_clk) disable iff (rst)
		(state_reg.ctl[11:10] == TMC_EDGE_BOTH) |=> (secondRiseArm && secondFallArm);
	endproperty
	a_edge_both: assert property (p_edge_both) else $error("second both edges not armed");

	property p_edge_rsvd;
		@(posedge ref_clk) disable iff (rst)
		(state_reg.ctl[3:2] == TMC_EDGE_RSVD) |=> !(firstRiseArm || firstFallArm);
	endproperty
	a_edge_rsvd: assert property (p_edge_rsvd) else $error("reserved edge armed");

	property p_rtc;
		@(posedge ref_clk) disable iff (rst)
		$rose(state_reg.ctl[TMC_CLOCK_COUNT_BIT]) |=> clockCountEn;
	endproperty
	a_rtc: assert property (p_rtc) else $error("clock count enable late");

	// Each control flag reaches its output one cycle after the register
	property p_second_inv;
		@(posedge ref_clk) disable iff (rst)
		1'b1 |=> secondInvert == $past(state_reg.ctl[TMC_SECOND_INV_BIT]);
	endproperty
	a_second_inv: assert property (p_second_inv) else $error("second invert wrong");

	property p_second_trig;
		@(posedge ref_clk) disable iff (rst)
		1'b1 |=> secondTrigEn == $past(state_reg.ctl[TMC_SECOND_TRIG_BIT]);
	endproperty
	a_second_trig: assert property (p_second_trig) else $error("second trigger wrong");

	property p_first_inv;
		@(posedge ref_clk) disable iff (rst)
		1'b1 |=> firstInvert == $past(state_reg.ctl[TMC_FIRST_INV_BIT]);
	endproperty
	a_first_inv: assert property (p_first_inv) else $error("first invert wrong");

	property p_first_trig;
		@(posedge ref_clk) disable iff (rst)
		1'b1 |=> firstTrigEn == $past(state_reg.ctl[TMC_FIRST_TRIG_BIT]);
	endproperty
	a_first_trig: assert property (p_first_trig) else $error("first trigger wrong");

	property p_second_stall;
		@(posedge ref_clk) disable iff (rst)
		(state_reg.ctl[TMC_SECOND_STALL_BIT] && state_reg.halt[1]) |=> !secondRun;
	endproperty
	a_second_stall: assert property (p_second_stall) else $error("second not stalled");

	property p_first_off;
		@(posedge ref_clk) disable iff (rst)
		!state_reg.ctl[TMC_FIRST_EN_BIT] |=> !firstRun;
	endproperty
	a_first_off: assert property (p_first_off) else $error("first timer runs while off");

	property p_edge_fall;
		@(posedge ref_clk) disable iff (rst)
		(state_reg.ctl[TMC_FIRST_EDGE_LSB +: 2] == TMC_EDGE_FALL)
		|=> (firstFallArm && !firstRiseArm);
	endproperty
	a_edge_fall: assert property (p_edge_fall) else $error("first falling edge wrong");

	// Clock counter setup is only code 1 of the global field
	property p_wide_clock;
		@(posedge ref_clk) disable iff (rst)
		1'b1 |=> wideClockMode == ($past(state_reg.cfg) == TMC_CFG_WIDE_CLOCK);
	endproperty
	a_wide_clock: assert property (p_wide_clock) else $error("wide clock decode wrong");

endmodule

// ==== tmc_mode_ctrl_tb.sv ====
`timescale 1ns/1ps
module tmc_mode_ctrl_tb;
	import tmc_pkg::*;

	logic        ref_clk;
	logic        rst;
	logic [3:0]  avsAddress;
	logic        avsRead;
	logic        avsWrite;
	logic [31:0] avsWriteData;
	logic [3:0]  avsByteEnable;
	logic [31:0] avsReadData;
	logic        avsWaitRequest;
	logic        cpuHalted;
	logic        wideMode;
	logic        wideClockMode;
	logic [1:0]  firstOp;
	logic        firstPwm;
	logic        firstEdgeTime;
	logic [1:0]  secondOp;
	logic        secondPwm;
	logic        secondEdgeTime;
	logic        firstRun;
	logic        secondRun;
	logic        firstRiseArm;
	logic        firstFallArm;
	logic        secondRiseArm;
	logic        secondFallArm;
	logic        firstTrigEn;
	logic        secondTrigEn;
	logic        firstInvert;
	logic        secondInvert;
	logic        clockCountEn;
	int          err_count;
	int          comparisons;
	int          b;
	logic        r;
	logic        f;

	tmc_mode_ctrl dut (.ref_clk(ref_clk), .rst(rst), .avsAddress(avsAddress),
		.avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
		.avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
		.avsWaitRequest(avsWaitRequest), .cpuHalted(cpuHalted), .wideMode(wideMode),
		.wideClockMode(wideClockMode), .firstOp(firstOp), .firstPwm(firstPwm),
		.firstEdgeTime(firstEdgeTime), .secondOp(secondOp), .secondPwm(secondPwm),
		.secondEdgeTime(secondEdgeTime), .firstRun(firstRun), .secondRun(secondRun),
		.firstRiseArm(firstRiseArm), .firstFallArm(firstFallArm),
		.secondRiseArm(secondRiseArm), .secondFallArm(secondFallArm),
		.firstTrigEn(firstTrigEn), .secondTrigEn(secondTrigEn),
		.firstInvert(firstInvert), .secondInvert(secondInvert),
		.clockCountEn(clockCountEn));

	// 250 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Single place where the run ends
	task automatic complete_run();
		if (err_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check1(input string name, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %b seen %b", name, exp, got);
		end
	endtask

	// One bus transfer; a spare edge first so a release never meets a new request
	task automatic bus_cycle(input logic wr, input logic [3:0] addr, input logic [31:0] wd,
			input logic [3:0] be, output logic [31:0] rd);
		int n;
		@(posedge ref_clk);
		avsAddress    <= addr;
		avsWriteData  <= wd;
		avsByteEnable <= be;
		avsWrite      <= wr;
		avsRead       <= ~wr;
		for (n = 0; n < 20; n++) begin
			@(posedge ref_clk);
			if (avsWaitRequest === 1'b0) break;
		end
		rd = avsReadData;
		avsWrite <= 1'b0;
		avsRead  <= 1'b0;
		if (n == 20) begin
			err_count++;
			complete_run();
		end
	endtask

	task automatic wr(input logic [3:0] addr, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] unused;
		bus_cycle(1'b1, addr, wd, be, unused);
	endtask

	task automatic rdchk(input string name, input logic [3:0] addr, input logic [31:0] exp);
		logic [31:0] rd;
		bus_cycle(1'b0, addr, 32'h0000_0000, 4'hF, rd);
		check32(name, exp, rd);
	endtask

	// Decoded outputs lag the register by a cycle; two edges leave margin
	task automatic settle();
		repeat (2) @(posedge ref_clk);
	endtask

	// The halt input crosses a synchroniser, so poll firstRun under a bound, then check both run flags
	task automatic wait_run(input logic exp);
		int n;
		for (n = 0; n < 10 && firstRun !== exp; n++) @(posedge ref_clk);
		check1("firstRun", exp, firstRun);
		check1("secondRun", exp, secondRun);
		if (n == 10) complete_run();
	endtask

	initial begin
		rst           = 1'b1;
		avsAddress    = 4'h0;
		avsRead       = 1'b0;
		avsWrite      = 1'b0;
		avsWriteData  = 32'h0000_0000;
		avsByteEnable = 4'h0;
		cpuHalted     = 1'b0;
		err_count     = 0;
		comparisons   = 0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		rdchk("second mode reset", TMC_SECOND_MODE_OFS, 32'h0000_0000);
		rdchk("control reset", TMC_CONTROL_OFS, 32'h0000_0000);
		check1("firstRun reset", 1'b0, firstRun);
		// Reserved control bits read zero; byte lane 1 only
		wr(TMC_CONTROL_OFS, 32'hFFFF_FFFF, 4'hF);
		rdchk("control all ones", TMC_CONTROL_OFS, 32'h0000_6F7F);
		wr(TMC_CONTROL_OFS, 32'h0000_0000, 4'hF);
		wr(TMC_CONTROL_OFS, 32'h0000_FFFF, 4'h2);
		rdchk("control lane one", TMC_CONTROL_OFS, 32'h0000_6F00);
		// Unmapped offset reads zero and leaves control alone
		wr(4'h1, 32'hFFFF_FFFF, 4'hF);
		rdchk("unmapped", 4'h1, 32'h0000_0000);
		rdchk("control kept", TMC_CONTROL_OFS, 32'h0000_6F00);
		// Walk each single-bit control so a swapped bit shows up
		for (b = 0; b < 15; b++) begin
			wr(TMC_CONTROL_OFS, 32'h1 << b, 4'hF);
			settle();
			check32("flags", {25'h0, b == 0, b == 8, b == 5, b == 13, b == 6, b == 14, b == 4},
				{25'h0, firstRun, secondRun, firstTrigEn, secondTrigEn,
				firstInvert, secondInvert, clockCountEn});
		end
		// Every edge code, code 2 arms nothing
		for (b = 0; b < 4; b++) begin
			wr(TMC_CONTROL_OFS, (b << 2) | (b << 10), 4'hF);
			settle();
			r = (b == 0 || b == 3);
			f = (b == 1 || b == 3);
			check32("edge arms", {28'h0, r, f, r, f}, {28'h0, firstRiseArm, firstFallArm,
				secondRiseArm, secondFallArm});
		end
		// Stall set: halt freezes both, release resumes
		wr(TMC_CONTROL_OFS, 32'h0000_0303, 4'hF);
		wait_run(1'b1);
		cpuHalted <= 1'b1;
		wait_run(1'b0);
		cpuHalted <= 1'b0;
		wait_run(1'b1);
		// Stall clear: halt has no effect
		wr(TMC_CONTROL_OFS, 32'h0000_0101, 4'hF);
		cpuHalted <= 1'b1;
		repeat (6) @(posedge ref_clk);
		wait_run(1'b1);
		cpuHalted <= 1'b0;
		// Split configuration: every second mode value decodes
		wr(TMC_GLOBAL_CFG_OFS, 32'h0000_0004, 4'hF);
		for (b = 0; b < 16; b++) begin
			wr(TMC_SECOND_MODE_OFS, 32'hFFFF_FFF0 | b, 4'hF);
			settle();
			check32("second mode", b, {28'h0, secondPwm, secondEdgeTime, secondOp});
			rdchk("second mode rd", TMC_SECOND_MODE_OFS, b);
		end
		// Wide configurations take the first mode register; its upper bits alternate
		for (b = 0; b < 8; b++) begin
			wr(TMC_FIRST_MODE_OFS, b[0] ? 32'h0000_000A : 32'h0000_0006, 4'hF);
			wr(TMC_GLOBAL_CFG_OFS, b, 4'hF);
			settle();
			check1("wideMode", b <= 1, wideMode);
			check1("wideClockMode", b == 1, wideClockMode);
			check32("firstOp", 32'h2, {30'h0, firstOp});
			check32("first mode", b[0] ? 32'h0000_000A : 32'h0000_0006,
				{28'h0, firstPwm, firstEdgeTime, firstOp});
			check32("second source", (b <= 1) ? (b[0] ? 32'h0000_000A : 32'h0000_0006) :
				32'h0000_000F, {28'h0, secondPwm, secondEdgeTime, secondOp});
		end
		// Reset in mid-run clears every register
		rst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		check1("firstRun after reset", 1'b0, firstRun);
		rdchk("config after reset", TMC_GLOBAL_CFG_OFS, 32'h0000_0000);
		rdchk("first mode after reset", TMC_FIRST_MODE_OFS, 32'h0000_0000);
		rdchk("second mode after reset", TMC_SECOND_MODE_OFS, 32'h0000_0000);
		rdchk("control after reset", TMC_CONTROL_OFS, 32'h0000_0000);
		complete_run();
	end

endmodule

// ==== tmc_pkg.sv ====
package tmc_pkg;

	// Register byte offsets
	localparam logic [3:0] TMC_GLOBAL_CFG_OFS  = 4'h0;
	localparam logic [3:0] TMC_FIRST_MODE_OFS  = 4'h4;
	localparam logic [3:0] TMC_SECOND_MODE_OFS = 4'h8;
	localparam logic [3:0] TMC_CONTROL_OFS     = 4'hC;

	// Reset values
	localparam logic [2:0]  TMC_GLOBAL_CFG_RST = 3'h0;
	localparam logic [3:0]  TMC_MODE_RST       = 4'h0;
	localparam logic [14:0] TMC_CONTROL_RST    = 15'h0000;

	// Mode register field positions
	localparam int TMC_MODE_FIELD_LSB = 0;
	localparam int TMC_CAPTURE_KIND_BIT = 2;
	localparam int TMC_ALT_MODE_BIT = 3;

	// Control register field positions
	localparam int TMC_FIRST_EN_BIT      = 0;
	localparam int TMC_FIRST_STALL_BIT   = 1;
	localparam int TMC_FIRST_EDGE_LSB    = 2;
	localparam int TMC_CLOCK_COUNT_BIT   = 4;
	localparam int TMC_FIRST_TRIG_BIT    = 5;
	localparam int TMC_FIRST_INV_BIT     = 6;
	localparam int TMC_SECOND_EN_BIT     = 8;
	localparam int TMC_SECOND_STALL_BIT  = 9;
	localparam int TMC_SECOND_EDGE_LSB   = 10;
	localparam int TMC_SECOND_TRIG_BIT   = 13;
	localparam int TMC_SECOND_INV_BIT    = 14;

	// Writable control bits; 12 and 7 stay zero
	localparam logic [14:0] TMC_CONTROL_WMASK = 15'h6F7F;

	// Mode field codes
	localparam logic [1:0] TMC_MODE_RESERVED = 2'h0;
	localparam logic [1:0] TMC_MODE_ONESHOT  = 2'h1;
	localparam logic [1:0] TMC_MODE_PERIODIC = 2'h2;
	localparam logic [1:0] TMC_MODE_CAPTURE  = 2'h3;

	// Edge select codes
	localparam logic [1:0] TMC_EDGE_RISE = 2'h0;
	localparam logic [1:0] TMC_EDGE_FALL = 2'h1;
	localparam logic [1:0] TMC_EDGE_RSVD = 2'h2;
	localparam logic [1:0] TMC_EDGE_BOTH = 2'h3;

	// Global configuration codes
	localparam logic [2:0] TMC_CFG_WIDE_TIMER = 3'h0;
	localparam logic [2:0] TMC_CFG_WIDE_CLOCK = 3'h1;

	typedef enum logic [1:0] {
		TMC_OP_OFF,
		TMC_OP_ONESHOT,
		TMC_OP_PERIODIC,
		TMC_OP_CAPTURE
	} tmc_op_e;

endpackage
